// >>> inc/rtcsc_pkg.sv
// Package of constants for the sub-second, reference and coarse trim block
// Assumes a single kernel clock domain
package rtcsc_pkg;
	localparam logic [3:0]  ADDR_CTRL       = 4'h0;
	localparam logic [3:0]  ADDR_PRESCALE   = 4'h1;
	localparam logic [3:0]  ADDR_SUBSECOND  = 4'h2;
	localparam logic [3:0]  ADDR_ADJUST     = 4'h3;
	localparam logic [3:0]  ADDR_TRIM       = 4'h4;
	localparam logic [3:0]  ADDR_STATUS     = 4'h5;
	localparam int          CTRL_INIT_BIT   = 0;
	localparam int          CTRL_MAINS_BIT  = 1;
	localparam int          CTRL_STDBY_BIT  = 2;
	localparam int          ADJ_ADD_ONE_SECOND_BIT   = 31;
	localparam int          TRIM_SIGN_BIT   = 7;
	localparam int          STAT_PEND_BIT   = 0;
	localparam int          STAT_CFG_BIT    = 1;
	localparam logic [6:0]  ASYNC_RESET     = 7'h7f;
	localparam logic [14:0] SYNC_RESET      = 15'h00ff;
	localparam logic [3:0]  WIN_FIRST       = 4'h7;
	localparam logic [3:0]  WIN_NEXT        = 4'h3;
	localparam logic [13:0] TICKS_PER_MIN   = 14'h3c00;
	localparam logic [5:0]  MINUTES_CYCLE   = 6'h3f;
	localparam logic [1:0]  ADD_TICKS       = 2'h2;
	typedef enum logic [1:0] {RTCSC_WAIT, RTCSC_OPEN} rtcsc_win_t;
endpackage

// >>> hdl/rtcsc_sync3.sv
// Three-stage synchroniser with agreement on the last two stages
// Assumes input is asynchronous to i_core_clk
`timescale 1ns/1ps
module rtcsc_sync3 (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_async,
	output logic      o_level
);
	logic [2:0] sr_reg;
	logic [2:0] sr_next;
	logic       lvl_reg;
	logic       lvl_next;
	always_comb begin
		sr_next  = {sr_reg[1:0], i_async};
		lvl_next = (sr_reg[2] == sr_reg[1]) ? sr_reg[2] : lvl_reg;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			sr_reg  <= 3'h0;
			lvl_reg <= 1'b0;
		end else begin
			sr_reg  <= sr_next;
			lvl_reg <= lvl_next;
		end
	end
	assign o_level = lvl_reg;
endmodule

// >>> hdl/rtcsc_top.sv
// Sub-second shift, mains reference alignment and coarse trim of a calendar clock
// Assumes software obeys the programming limits; one kernel clock
`timescale 1ns/1ps
module rtcsc_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_mains_reference_input,
	output logic [31:0]      o_rdata,
	output logic             o_one_hertz_tick,
	output logic             o_prescaler_256hz_tick
);
	logic        ref_lvl;
	logic [2:0]  ctrl_reg, ctrl_next;
	logic [6:0]  adiv_reg, adiv_next;
	logic [14:0] sdiv_reg, sdiv_next;
	logic [7:0]  trim_reg, trim_next;
	logic [15:0] ss_reg, ss_next;
	logic [6:0]  acnt_reg, acnt_next;
	logic        pend_reg, pend_next;
	logic [15:0] sub_reg, sub_next;
	logic        add1_reg, add1_next;
	logic [1:0]  cfg_sr_reg, cfg_sr_next;
	logic        apre_reg, apre_next;
	logic        spre_reg, spre_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [13:0] tmin_reg, tmin_next;
	logic [5:0]  min_reg, min_next;
	logic [1:0]  owe_reg, owe_next;
	logic        mask_reg, mask_next;
	logic        ref_d_reg, ref_d_next;
	logic [3:0]  wcnt_reg, wcnt_next;
	logic        locked_reg, locked_next;
	rtcsc_pkg::rtcsc_win_t win_reg, win_next;
	logic        detect_on, running, atick, step, ref_edge, reload, wr_adj;
	logic [15:0] ss_dec;
	logic [3:0]  win_len;

	rtcsc_sync3 u_ref_sync (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_async    (i_mains_reference_input),
		.o_level    (ref_lvl)
	);

	always_comb begin
		detect_on = ctrl_reg[rtcsc_pkg::CTRL_MAINS_BIT]
			& ~ctrl_reg[rtcsc_pkg::CTRL_STDBY_BIT];
		running   = ~cfg_sr_reg[1];
		wr_adj    = i_wr && i_addr == rtcsc_pkg::ADDR_ADJUST;
		ref_edge  = ref_lvl & ~ref_d_reg;
		atick     = running && acnt_reg == 7'h0;
		step      = (atick & ~mask_reg) | (running & owe_reg != 2'h0);
		win_len   = locked_reg ? rtcsc_pkg::WIN_NEXT : rtcsc_pkg::WIN_FIRST;
		reload    = detect_on && running
			&& win_reg == rtcsc_pkg::RTCSC_OPEN && ref_edge;
		ss_dec    = ss_reg - 16'h1;
		ctrl_next = ctrl_reg;
		adiv_next = adiv_reg;
		sdiv_next = sdiv_reg;
		trim_next = trim_reg;
		if (i_wr) begin
			unique case (i_addr)
				rtcsc_pkg::ADDR_CTRL:      ctrl_next = i_wdata[2:0];
				rtcsc_pkg::ADDR_PRESCALE: begin
					if (cfg_sr_reg[1]) begin
						sdiv_next = i_wdata[14:0];
						adiv_next = i_wdata[22:16];
					end
				end
				rtcsc_pkg::ADDR_TRIM: begin
					if (cfg_sr_reg[1]) begin
						trim_next = i_wdata[7:0];
					end
				end
				default: ;
			endcase
		end
		cfg_sr_next = {cfg_sr_reg[0], ctrl_reg[rtcsc_pkg::CTRL_INIT_BIT]};
		acnt_next = ~running ? adiv_reg : (acnt_reg == 7'h0 ? adiv_reg : acnt_reg - 7'h1);
		apre_next = atick;
		// Minute and 64-minute cycle counters
		tmin_next = tmin_reg;
		min_next  = min_reg;
		// Mask stays armed until the next prescaler tick consumes it
		mask_next = (atick || ~running) ? 1'b0 : mask_reg;
		owe_next  = (owe_reg != 2'h0 && running) ? owe_reg - 2'h1 : owe_reg;
		if (~running) begin
			tmin_next = 14'h0;
			min_next  = 6'h0;
			owe_next  = 2'h0;
		end else if (atick) begin
			if (tmin_reg == rtcsc_pkg::TICKS_PER_MIN - 14'h1) begin
				tmin_next = 14'h0;
				min_next  = (min_reg == rtcsc_pkg::MINUTES_CYCLE) ? 6'h0 : min_reg + 6'h1;
			end else begin
				tmin_next = tmin_reg + 14'h1;
			end
			if (tmin_reg == 14'h0 && min_reg < {trim_reg[4:0], 1'b0}) begin
				if (trim_reg[rtcsc_pkg::TRIM_SIGN_BIT]) begin
					mask_next = 1'b1;
				end else begin
					owe_next = rtcsc_pkg::ADD_TICKS;
				end
			end
		end
		// Synchronous prescaler and shift
		ss_next   = ss_reg;
		spre_next = 1'b0;
		if (~running) begin
			ss_next = {1'b0, sdiv_reg};
		end else if (reload) begin
			ss_next   = {1'b0, sdiv_reg};
			spre_next = 1'b1;
		end else if (step) begin
			if (ss_reg == 16'h0) begin
				ss_next   = {1'b0, sdiv_reg};
				spre_next = 1'b1;
			end else begin
				ss_next = ss_dec;
			end
		end
		pend_next = pend_reg;
		sub_next  = sub_reg;
		add1_next = add1_reg;
		if (pend_reg && running && !step && !reload) begin
			ss_next   = ss_reg + sub_reg;
			spre_next = add1_reg;
			pend_next = 1'b0;
		end
		if (wr_adj && !detect_on) begin
			pend_next = 1'b1;
			sub_next  = {1'b0, i_wdata[14:0]};
			add1_next = i_wdata[rtcsc_pkg::ADJ_ADD_ONE_SECOND_BIT];
		end
		// Reference detection window
		ref_d_next  = ref_lvl;
		win_next    = win_reg;
		wcnt_next   = wcnt_reg;
		locked_next = locked_reg;
		if (~detect_on) begin
			win_next    = rtcsc_pkg::RTCSC_WAIT;
			locked_next = 1'b0;
		end else if (reload) begin
			win_next    = rtcsc_pkg::RTCSC_WAIT;
			locked_next = 1'b1;
		end else begin
			unique case (win_reg)
				rtcsc_pkg::RTCSC_WAIT: begin
					if (atick && ss_reg == 16'h0) begin
						win_next  = rtcsc_pkg::RTCSC_OPEN;
						wcnt_next = win_len;
					end
				end
				rtcsc_pkg::RTCSC_OPEN: begin
					if (atick) begin
						if (wcnt_reg <= 4'h1) begin
							win_next    = rtcsc_pkg::RTCSC_WAIT;
							locked_next = 1'b0;
						end else begin
							wcnt_next = wcnt_reg - 4'h1;
						end
					end
				end
			endcase
		end
		rdata_next = 32'h0;
		if (i_rd) begin
			unique case (i_addr)
				rtcsc_pkg::ADDR_CTRL:      rdata_next = {29'h0, ctrl_reg};
				rtcsc_pkg::ADDR_PRESCALE:  rdata_next = {9'h0, adiv_reg, 1'b0, sdiv_reg};
				rtcsc_pkg::ADDR_SUBSECOND: rdata_next = {16'h0, ss_reg};
				rtcsc_pkg::ADDR_TRIM:      rdata_next = {24'h0, trim_reg};
				rtcsc_pkg::ADDR_STATUS:    rdata_next = {30'h0, cfg_sr_reg[1], pend_reg};
				default:                   rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ctrl_reg   <= 3'h0;
			adiv_reg   <= rtcsc_pkg::ASYNC_RESET;
			sdiv_reg   <= rtcsc_pkg::SYNC_RESET;
			trim_reg   <= 8'h0;
			ss_reg     <= {1'b0, rtcsc_pkg::SYNC_RESET};
			acnt_reg   <= rtcsc_pkg::ASYNC_RESET;
			pend_reg   <= 1'b0;
			sub_reg    <= 16'h0;
			add1_reg   <= 1'b0;
			cfg_sr_reg <= 2'h0;
			apre_reg   <= 1'b0;
			spre_reg   <= 1'b0;
			rdata_reg  <= 32'h0;
			tmin_reg   <= 14'h0;
			min_reg    <= 6'h0;
			owe_reg    <= 2'h0;
			mask_reg   <= 1'b0;
			ref_d_reg  <= 1'b0;
			wcnt_reg   <= 4'h0;
			locked_reg <= 1'b0;
			win_reg    <= rtcsc_pkg::RTCSC_WAIT;
		end else begin
			ctrl_reg   <= ctrl_next;
			adiv_reg   <= adiv_next;
			sdiv_reg   <= sdiv_next;
			trim_reg   <= trim_next;
			ss_reg     <= ss_next;
			acnt_reg   <= acnt_next;
			pend_reg   <= pend_next;
			sub_reg    <= sub_next;
			add1_reg   <= add1_next;
			cfg_sr_reg <= cfg_sr_next;
			apre_reg   <= apre_next;
			spre_reg   <= spre_next;
			rdata_reg  <= rdata_next;
			tmin_reg   <= tmin_next;
			min_reg    <= min_next;
			owe_reg    <= owe_next;
			mask_reg   <= mask_next;
			ref_d_reg  <= ref_d_next;
			wcnt_reg   <= wcnt_next;
			locked_reg <= locked_next;
			win_reg    <= win_next;
		end
	end

	assign o_rdata                = rdata_reg;
	assign o_one_hertz_tick       = spre_reg;
	assign o_prescaler_256hz_tick = apre_reg;

	// Assertions
	a_read_subsec: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rd && i_addr == rtcsc_pkg::ADDR_SUBSECOND |=> o_rdata == {16'h0, $past(ss_reg)})
		else $error("subsecond read wrong");
	a_pend_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_adj && !detect_on |=> pend_reg)
		else $error("pending flag not set");
	a_shift_add: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		pend_reg && running && !step && !reload && !wr_adj |=>
		!pend_reg && ss_reg == $past(ss_reg) + $past(sub_reg))
		else $error("shift not applied");
	a_add_second: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		pend_reg && add1_reg && running && !step && !reload |=> o_one_hertz_tick)
		else $error("second not added");
	a_cfg_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(ctrl_reg[rtcsc_pkg::CTRL_INIT_BIT]) |-> ##[1:2] cfg_sr_reg[1])
		else $error("config flag late");
	a_reload_tick: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		reload |=> o_one_hertz_tick && ss_reg == {1'b0, sdiv_reg})
		else $error("reload missing");
	a_standby_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		ctrl_reg[rtcsc_pkg::CTRL_STDBY_BIT] |-> !reload)
		else $error("detect in standby");
	a_neg_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		mask_reg && atick && owe_reg == 2'h0 |-> !step)
		else $error("tick not masked");
	a_pos_add: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		owe_reg == rtcsc_pkg::ADD_TICKS && running |-> step ##1 step)
		else $error("ticks not inserted");
	a_window_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(win_reg == rtcsc_pkg::RTCSC_OPEN) |-> wcnt_reg == ($past(locked_reg) ?
			rtcsc_pkg::WIN_NEXT : rtcsc_pkg::WIN_FIRST))
		else $error("window length wrong");
	a_cfg_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		cfg_sr_reg[1] |=> min_reg == 6'h0 && tmin_reg == 14'h0)
		else $error("trim cycle not restarted");
endmodule

// >>> testbench/rtcsc_mains_model.sv
// Mains reference source model for the trim block bench
// Assumes arm is a one-cycle pulse from the bench on the kernel clock
`timescale 1ns/1ps
module rtcsc_mains_model #(
	parameter int DELAY = 256
) (
	input  wire logic i_core_clk,
	input  wire logic i_arm,
	output logic      o_level
);
	int cnt = 0;
	// One rising edge DELAY cycles after arm, then back low
	always @(posedge i_core_clk) begin
		if (i_arm)
			cnt <= DELAY + 64;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign o_level = (cnt > 0) && (cnt <= 64);
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the sub-second, reference and coarse trim block
// Assumes one-cycle strobes and read data registered one cycle later
`timescale 1ns/1ps
module testbench;
	localparam logic [3:0] A_CT = rtcsc_pkg::ADDR_CTRL;
	localparam logic [3:0] A_PR = rtcsc_pkg::ADDR_PRESCALE;
	localparam logic [3:0] A_SS = rtcsc_pkg::ADDR_SUBSECOND;
	localparam logic [3:0] A_AD = rtcsc_pkg::ADDR_ADJUST;
	localparam logic [3:0] A_TR = rtcsc_pkg::ADDR_TRIM;
	localparam logic [3:0] A_ST = rtcsc_pkg::ADDR_STATUS;
	logic        i_core_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [3:0]  i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        arm = 1'b0;
	logic        ref_level;
	logic [31:0] o_rdata;
	logic        o_one_hertz_tick;
	logic        o_prescaler_256hz_tick;
	logic [31:0] rv;
	int          mismatches = 0;
	int          checks_done = 0;
	int          n, m, t0;

	rtcsc_top rtcsc_top_i (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_mains_reference_input(ref_level), .o_rdata(o_rdata),
		.o_one_hertz_tick(o_one_hertz_tick),
		.o_prescaler_256hz_tick(o_prescaler_256hz_tick)
	);
	rtcsc_mains_model #(.DELAY(256)) rtcsc_mains_model_i (
		.i_core_clk(i_core_clk), .i_arm(arm), .o_level(ref_level)
	);

	initial begin
		forever #20 i_core_clk = ~i_core_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		rv = o_rdata;
	endtask

	// Write followed by a read in the very next cycle
	task automatic wr_rd(input logic [3:0] a, input logic [31:0] d, input logic [3:0] ra);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= ra;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		rv = o_rdata;
	endtask

	// Counts cycles up to the next pulse of the chosen tick
	task automatic wait_tick(input bit fast, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			cnt++;
		end while ((fast ? o_prescaler_256hz_tick : o_one_hertz_tick) !== 1'b1 && cnt < lim);
		if (cnt >= lim) begin
			check("timeout", 32'h1, 32'h0);
			conclude();
		end
	endtask

	task automatic cfg(input logic [31:0] pre, input logic [31:0] trim);
		wr(A_CT, 32'h1);
		rd(A_ST);
		rd(A_ST);
		check("cfg_flag", rv & 32'h2, 32'h2);
		wr(A_PR, pre);
		wr(A_TR, trim);
	endtask

	task automatic go(input logic [31:0] ctrl, output int t);
		wr(A_CT, ctrl);
		wait_tick(1'b0, 40000, t);
	endtask

	initial begin
		repeat (6) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(4'hf);
		check("unmapped", rv, 32'h0);
		cfg(32'h00067fff, 32'h9f);
		rd(A_SS);
		check("ss_max", rv, 32'h7fff);
		rd(A_TR);
		check("trim_rb", rv, 32'h9f);
		cfg(32'h0006000f, 32'h0);
		rd(A_SS);
		check("ss_cfg", rv, 32'hf);
		go(32'h0, t0);
		wait_tick(1'b0, 200, n);
		check("sec_len", n, 112);
		wr(A_TR, 32'h9f);
		rd(A_TR);
		check("trim_lock", rv, 32'h0);
		wait_tick(1'b1, 20, n);
		wait_tick(1'b1, 20, n);
		check("tick_len", n, 7);
		rd(A_SS);
		check("ss_top", rv & 32'h8000, 32'h0);
		wait_tick(1'b0, 200, n);
		wr_rd(A_AD, 32'h3, A_ST);
		check("pend_set", rv & 32'h1, 32'h1);
		wait_tick(1'b0, 200, n);
		check("shift_len", n + 3, 133);
		rd(A_ST);
		check("pend_clr", rv & 32'h1, 32'h0);
		wait_tick(1'b0, 200, n);
		wr(A_AD, 32'h80000003);
		wait_tick(1'b0, 200, n);
		check("add_one_second_soon", n, 1);
		wait_tick(1'b0, 200, m);
		check("add_one_second_len", n + m + 2, 133);
		cfg(32'h0006000f, 32'h0);
		go(32'h0, t0);
		cfg(32'h0006000f, 32'h01);
		go(32'h0, n);
		check("trim_pos", n, t0 - 14);
		cfg(32'h0006000f, 32'h81);
		go(32'h0, n);
		check("trim_neg", n, t0 + 7);
		cfg(32'h007f00ff, 32'h0);
		go(32'h2, n);
		@(posedge i_core_clk);
		arm <= 1'b1;
		@(posedge i_core_clk);
		arm <= 1'b0;
		wait_tick(1'b0, 300, n);
		check("ref_align", n >= 256 && n <= 270, 1'b1);
		wait_tick(1'b0, 33000, n);
		check("ref_lost", n >= 32641 && n <= 32768, 1'b1);
		// Standby while the short window is open: the edge must be ignored
		wr(A_CT, 32'h6);
		@(posedge i_core_clk);
		arm <= 1'b1;
		@(posedge i_core_clk);
		arm <= 1'b0;
		m = 0;
		repeat (300) begin
			@(posedge i_core_clk);
			#1;
			if (o_one_hertz_tick === 1'b1)
				m++;
		end
		check("stdby_ref", m, 0);
		conclude();
	end
endmodule
